// ---- inc/afs_pkg.sv ----
/*
 Shared constants for the converter output formatter and standby block.
 Assumes a single 20 MHz conversion clock and an active-high async reset.
*/
package afs_pkg;
    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int AFS_DATA_W = 10;
    localparam int AFS_PIPE_DEPTH = 6;
    localparam int AFS_LAT_W = 3;
    localparam logic [AFS_LAT_W-1:0] AFS_FILL_CYCLES = 3'h6;
    localparam logic [AFS_LAT_W-1:0] AFS_FILL_RESET = 3'h0;
    localparam logic [AFS_DATA_W-1:0] AFS_WORD_RESET = 10'h000;
    localparam logic [AFS_DATA_W-1:0] AFS_MID_CODE = 10'h200;
    localparam int AFS_MSB = AFS_DATA_W - 1;
    localparam int AFS_BUF_DEPTH = 2;

    typedef enum logic [1:0] {
        AFS_STANDBY,
        AFS_FILL,
        AFS_RUN
    } afs_state_t;

    function automatic logic [AFS_DATA_W-1:0] afs_format(
        input logic [AFS_DATA_W-1:0] ob, input logic twos);
        afs_format = {ob[AFS_MSB] ^ twos, ob[AFS_MSB-1:0]};
    endfunction
endpackage

// ---- inc/afs_stream_if.sv ----
/*
 Valid/ready word channel between the formatter core and its output buffer.
 Assumes both ends share clock_in.
*/
`timescale 1ns/1ps
interface afs_stream_if;
    import afs_pkg::*;
    logic valid;
    logic ready;
    logic [AFS_DATA_W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

// ---- logic/afs_buffer.sv ----
/*
 Two-entry word buffer with valid and ready on both sides.
 Assumes the source and sink share clock_in; flush empties it.
*/
`timescale 1ns/1ps
module afs_buffer
    import afs_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic flush_in,
    afs_stream_if.dst up,
    output logic out_valid_out,
    output logic [AFS_DATA_W-1:0] out_data_out,
    input wire logic out_ready_in
);
    logic [AFS_DATA_W-1:0] mem [AFS_BUF_DEPTH];
    logic rd_idx;
    logic wr_idx;
    logic [1:0] count;
    logic push;
    logic pop;

    assign up.ready = (count != 2'h2) && !flush_in;
    assign push = up.valid && up.ready;
    assign pop = out_valid_out && out_ready_in;
    assign out_valid_out = (count != 2'h0) && !flush_in;
    assign out_data_out = mem[rd_idx];

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            count <= 2'h0;
            rd_idx <= 1'b0;
            wr_idx <= 1'b0;
        end else if (flush_in) begin
            count <= 2'h0;
            rd_idx <= 1'b0;
            wr_idx <= 1'b0;
        end else begin
            if (push) begin
                wr_idx <= ~wr_idx;
            end
            if (pop) begin
                rd_idx <= ~rd_idx;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            mem[0] <= AFS_WORD_RESET;
            mem[1] <= AFS_WORD_RESET;
        end else if (push) begin
            mem[wr_idx] <= up.data;
        end
    end
endmodule // afs_buffer

// ---- logic/afs_output_format.sv ----
/*
 Output side of a 10-bit pipelined converter: latency pipeline, standby
 handling, offset-binary or two's-complement coding, buffered word output.
 Assumes sample_in is a raw offset-binary code on clock_in; control pins are
 asynchronous and are synchronised here. Assumes the capture side runs on
 clock_in and drives out_ready_in from logic on that clock.
 standby_out is a status for a supervisor, never a clock.
*/
// Operation
// [RL1] Power-down request high holds standby and stops conversion activity.
// [RL2] Standby output words are undefined; capture must not use them as valid.
// [RL3] Standby destroys pipeline contents; discard words until refilled.
// [RL4] Standby entered and held regardless of clock running or its rate.
// [RL5] Format select high gives two's-complement words.
// [RL6] Format select low gives offset-binary words.
// [RL7] Each result leaves as a 10-bit parallel word.
// [RL8] Each output line drives one receiver; buffering downstream advised.
// [RL9] One word per clock, lagging its sample by fixed latency.
// [RL10] Output words change only after the rising clock edge.
// [RL11] Offset-binary mid-scale step lies between 0x1ff and 0x200.
// [RL12] Two's-complement equals offset-binary with MSB inverted.
`timescale 1ns/1ps
module afs_output_format
    import afs_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic power_down_request_in,
    input wire logic format_select_in,
    input wire logic [AFS_DATA_W-1:0] sample_in,
    input wire logic out_ready_in,
    output logic [AFS_DATA_W-1:0] data_out,
    output logic data_valid_out,
    output logic standby_out,
    output logic sample_ready_out
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pd_sync;
    logic [2:0] fmt_sync;
    logic pd_level;
    logic fmt_level;
    logic [AFS_DATA_W-1:0] pipe [AFS_PIPE_DEPTH];
    logic [AFS_LAT_W-1:0] fill_count;
    logic [AFS_DATA_W-1:0] fmt_word;
    afs_state_t state;
    afs_state_t next_state;
    afs_stream_if chan ();

    // Power-down chain: nothing but the next stage reads stage one
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pd_sync <= 3'h0;
        end else begin
            pd_sync <= {pd_sync[1:0], power_down_request_in};
        end
    end

    // Format chain, same three stages
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            fmt_sync <= 3'h0;
        end else begin
            fmt_sync <= {fmt_sync[1:0], format_select_in};
        end
    end

    // Accept a change only once stages two and three agree
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pd_level <= 1'b0;
        end else if (pd_sync[1] == pd_sync[2]) begin
            pd_level <= pd_sync[2];
        end
    end

    // Format is meant as a strap; a change in flight recodes a few words
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            fmt_level <= 1'b0;
        end else if (fmt_sync[1] == fmt_sync[2]) begin
            fmt_level <= fmt_sync[2];
        end
    end

    // ------------------------------------------------------------
    // Standby state machine
    // ------------------------------------------------------------
    // Leaves standby only on the synchronised level, then refills in full
    // before any word is offered, so no corrupted stage reaches the output
    always_comb begin
        next_state = state;
        case (state)
            AFS_STANDBY: begin
                if (!pd_level) begin
                    next_state = AFS_FILL;
                end
            end
            AFS_FILL: begin
                if (pd_level) begin
                    next_state = AFS_STANDBY; // RL1
                end else if (fill_count == AFS_FILL_CYCLES) begin
                    next_state = AFS_RUN; // RL3
                end
            end
            AFS_RUN: begin
                if (pd_level) begin
                    next_state = AFS_STANDBY; // RL1
                end
            end
            default: next_state = AFS_STANDBY;
        endcase
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state <= AFS_STANDBY;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // State decode
    // ------------------------------------------------------------
    logic in_standby;
    logic in_fill;
    logic in_run;

    assign in_standby = (state == AFS_STANDBY);
    assign in_fill = (state == AFS_FILL);
    assign in_run = (state == AFS_RUN);

    // Standby flag is combinational from the pin: holds with no clock edges
    // A pin pulse caught on fewer than two consecutive edges shows here only
    assign standby_out = power_down_request_in || in_standby; // RL4

    // ------------------------------------------------------------
    // Latency pipeline
    // ------------------------------------------------------------
    // Fill counter saturates at the fill length and clears outside fill
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            fill_count <= AFS_FILL_RESET;
        end else if (!in_fill) begin
            fill_count <= AFS_FILL_RESET; // RL3
        end else if (fill_count != AFS_FILL_CYCLES) begin
            fill_count <= fill_count + 3'h1;
        end
    end

    // Pipeline stalls with the buffer so no word is lost
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < AFS_PIPE_DEPTH; i++) begin
                pipe[i] <= AFS_WORD_RESET;
            end
        end else if (in_standby) begin
            // Contents corrupted on purpose; no stale sample survives
            for (int i = 0; i < AFS_PIPE_DEPTH; i++) begin
                pipe[i] <= ~AFS_WORD_RESET; // RL3
            end
        end else if (chan.ready || in_fill) begin
            pipe[0] <= sample_in; // RL9
            for (int i = 1; i < AFS_PIPE_DEPTH; i++) begin
                pipe[i] <= pipe[i-1]; // RL9
            end
        end
    end

    assign sample_ready_out = !in_standby && (chan.ready || in_fill);

    // ------------------------------------------------------------
    // Coding and buffered output
    // ------------------------------------------------------------
    // Offset binary: mid-scale step 0x1ff to 0x200 passes unchanged
    assign fmt_word = afs_format(pipe[AFS_PIPE_DEPTH-1], fmt_level); // RL5 RL6 RL11 RL12
    assign chan.data = fmt_word;
    // Synchronised level only: the raw pin must not reach the buffer's flip-flops
    assign chan.valid = in_run && !pd_level; // RL2

    // ------------------------------------------------------------
    // Two-entry buffer
    // ------------------------------------------------------------
    // Absorbs the lag between a capture stall and the pipeline stall
    logic buf_valid;
    logic [AFS_DATA_W-1:0] buf_data;

    afs_buffer u_buf (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .flush_in(in_standby),
        .up(chan),
        .out_valid_out(buf_valid),
        .out_data_out(buf_data),
        .out_ready_in(out_ready_in)
    );

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    // Registered output word changes only on the rising edge
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            data_out <= AFS_WORD_RESET;
        end else if (buf_valid && out_ready_in) begin
            data_out <= buf_data; // RL7 RL10
        end
    end

    // One pulse per word; a stalled capture side leaves it low
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            data_valid_out <= 1'b0;
        end else begin
            data_valid_out <= buf_valid && out_ready_in && !in_standby; // RL2
        end
    end
endmodule // afs_output_format

// ---- test/afs_chk.sv ----
/* Port checker for afs_output_format.
   Assumes one clock and an async active-high reset. */
`timescale 1ns/1ps
module afs_chk
    import afs_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic power_down_request_in,
    input wire logic format_select_in,
    input wire logic out_ready_in,
    input wire logic [AFS_DATA_W-1:0] data_out,
    input wire logic data_valid_out,
    input wire logic standby_out,
    input wire logic sample_ready_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // --------
    // Standby
    // --------
    AST_PD_FLAG: assert property (power_down_request_in |-> standby_out)
        else $error("standby flag low under request");
    AST_PD_NO_WORD: assert property (power_down_request_in[*7] |-> !data_valid_out)
        else $error("word delivered in standby");
    AST_PD_NO_TAKE: assert property (power_down_request_in[*6] |-> !sample_ready_out)
        else $error("sample taken in standby");
    AST_PD_ENTER: assert property ($rose(power_down_request_in) |-> ##[1:5] !sample_ready_out)
        else $error("standby not entered");
    AST_REFILL: assert property ($fell(standby_out) |-> !data_valid_out[*6])
        else $error("stale word after standby");
    AST_RESUME: assert property ($fell(standby_out) && out_ready_in |-> ##[0:12] sample_ready_out)
        else $error("conversion not resumed");
    // --------
    // Output word
    // --------
    AST_HOLD: assert property (!data_valid_out |-> $stable(data_out))
        else $error("word changed without valid");
    AST_STALL: assert property (!out_ready_in[*2] |-> !data_valid_out)
        else $error("word delivered while stalled");
    cover property ($fell(standby_out));
    cover property (data_valid_out && format_select_in);
    cover property (!out_ready_in[*4] ##1 out_ready_in);
endmodule // afs_chk
bind afs_output_format afs_chk u_chk (.clock_in, .rst_in, .power_down_request_in,
    .format_select_in, .out_ready_in, .data_out, .data_valid_out, .standby_out,
    .sample_ready_out);

// ---- test/afs_capture.sv ----
/* Capture logic model latching delivered words.
   Assumes the converter's clock; stall comes from the bench. */
`timescale 1ns/1ps
module afs_capture
    import afs_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic stall_in,
    input wire logic valid_in,
    input wire logic [AFS_DATA_W-1:0] data_in,
    output logic ready_out,
    output logic [AFS_DATA_W-1:0] word_out,
    output logic [15:0] count_out
);
    // --------
    // Capture
    // --------
    // Single receiver on every data line
    assign ready_out = !stall_in;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            word_out <= 10'h000;
            count_out <= 16'h0000;
        end else if (valid_in) begin
            word_out <= data_in;
            count_out <= count_out + 16'h0001;
        end
    end
endmodule // afs_capture

// ---- test/adc_output_format_standby_tb.sv ----
/* Self-checking bench for afs_output_format.
   Assumes afs_capture as far side and afs_chk bound to afs_output_format. */
`timescale 1ns/1ps
module adc_output_format_standby_tb;
    import afs_pkg::*;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic pd = 1'b0;
    logic fmt = 1'b0;
    logic stall = 1'b0;
    logic clk_run = 1'b1;
    logic inc = 1'b0;
    logic took = 1'b0;
    logic [AFS_DATA_W-1:0] smp = 10'h000;
    logic [AFS_DATA_W-1:0] dout;
    logic [AFS_DATA_W-1:0] word;
    logic dval, power_down_request, srdy, rdy;
    logic [15:0] cnt;
    int n_mismatch = 0;
    int n_checks = 0;
    // --------
    // Harness
    // --------
    // Clock can be parked low to show standby needs no clock
    initial begin
        forever begin
            #25;
            if (clk_run) clock_in = ~clock_in;
        end
    end
    afs_output_format DUT (.clock_in, .rst_in, .power_down_request_in(pd),
        .format_select_in(fmt), .sample_in(smp), .out_ready_in(rdy), .data_out(dout),
        .data_valid_out(dval), .standby_out(power_down_request), .sample_ready_out(srdy));
    afs_capture cap (.clock_in, .rst_in, .stall_in(stall), .valid_in(dval),
        .data_in(dout), .ready_out(rdy), .word_out(word), .count_out(cnt));
    always @(posedge clock_in) took <= srdy;
    always @(negedge clock_in) begin
        if (inc && took)
            smp <= smp + 10'h001;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wait_valid(input int lim);
        for (int i = 0; i < lim && dval !== 1'b1; i++)
            @(negedge clock_in);
        if (dval !== 1'b1) begin
            n_mismatch++;
            end_of_test();
        end
    endtask
    // --------
    // Scenarios
    // --------
    task automatic scen_format();
        logic [10:0] tab [6] = '{11'h1ff, 11'h200, 11'h5ff, 11'h600, 11'h400, 11'h3ff};
        foreach (tab[i]) begin
            fmt = tab[i][10];
            smp = tab[i][9:0];
            repeat (20) @(negedge clock_in);
            wait_valid(20);
            check(dout, {tab[i][9] ^ tab[i][10], tab[i][8:0]});
        end
    endtask
    task automatic scen_stream();
        logic [9:0] prev;
        logic seen;
        fmt = 1'b0;
        inc = 1'b1;
        seen = 1'b0;
        for (int c = 0; c < 120; c++) begin
            stall = (c % 7 < 3) || (c > 60 && c < 75);
            @(negedge clock_in);
            if (dval && c > 30) begin
                if (seen) check(dout, 10'(prev + 10'h001));
                prev = dout;
                seen = 1'b1;
            end
            if (c == 74) check(srdy, 1'b0);
        end
        inc = 1'b0;
        stall = 1'b0;
    endtask
    task automatic scen_standby();
        logic [15:0] c0;
        smp = 10'h155;
        repeat (20) @(negedge clock_in);
        clk_run = 1'b0;
        pd = 1'b1;
        #100;
        check(power_down_request, 1'b1);
        clk_run = 1'b1;
        repeat (6) @(negedge clock_in);
        c0 = cnt;
        repeat (10) @(negedge clock_in);
        check(cnt, c0);
        check(srdy, 1'b0);
        pd = 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(negedge clock_in);
            check(dval, 1'b0);
        end
        wait_valid(40);
        check(dout, 10'h155);
        @(negedge clock_in);
        check(word, 10'h155);
    endtask
    initial begin
        repeat (5) @(negedge clock_in);
        rst_in = 1'b0;
        scen_format();
        scen_stream();
        scen_standby();
        end_of_test();
    end
endmodule // adc_output_format_standby_tb
